// ==== core/pos_rx_pkg.sv ====
// Package with constants and types for the packet receive port
package pos_rx_pkg;
	localparam int ADDR_W = 5;
	localparam int NUM_FIFOS = 4;
	localparam int DATA_W = 64;
	localparam int PAD_W = 3;
	localparam int FIFO_DEPTH = 16;
	localparam int FIFO_PTR_W = 4;
	localparam logic [1:0] WIDTH_16 = 2'h1;
	localparam logic [1:0] WIDTH_32 = 2'h2;
	localparam logic [1:0] WIDTH_64 = 2'h3;
	localparam logic [4:0] BASE_ADDR_RST = 5'h00;
	localparam logic [1:0] CMD_NONE = 2'h0;
	localparam logic [1:0] CMD_POLL = 2'h1;
	localparam logic [1:0] CMD_READ = 2'h2;
	localparam int LINK_QUIET_LIMIT = 6;
	typedef enum logic [1:0] {
		LINK_IDLE,
		LINK_SELECT,
		LINK_READ
	} link_state_e;
endpackage : pos_rx_pkg

// ==== core/pos_rx_if.sv ====
// Interface joining the receive port and the link-layer reader
`timescale 1ns/1ps
`default_nettype none
interface pos_rx_if;
	logic [4:0] rx_port_address;
	logic rx_enable_n;
	logic rx_stop_after_packet;
	logic [63:0] rx_word_bus;
	logic rx_word_bus_oe;
	logic rx_start_of_packet;
	logic rx_end_of_packet;
	logic [2:0] rx_pad_count;
	logic rx_packet_error;
	logic rx_word_valid;
	logic rx_bus_parity;
	logic rx_qual_oe;
	logic rx_polled_frame_avail;
	logic rx_polled_oe;
	logic [3:0] rx_direct_frame_avail;
	logic rx_direct_oe;
	modport phy (
		input rx_port_address, rx_enable_n, rx_stop_after_packet,
		output rx_word_bus, rx_word_bus_oe, rx_start_of_packet, rx_end_of_packet,
		output rx_pad_count, rx_packet_error, rx_word_valid, rx_bus_parity,
		output rx_qual_oe, rx_polled_frame_avail, rx_polled_oe,
		output rx_direct_frame_avail, rx_direct_oe
	);
	modport link (
		output rx_port_address, rx_enable_n, rx_stop_after_packet,
		input rx_word_bus, rx_word_bus_oe, rx_start_of_packet, rx_end_of_packet,
		input rx_pad_count, rx_packet_error, rx_word_valid, rx_bus_parity,
		input rx_qual_oe, rx_polled_frame_avail, rx_polled_oe,
		input rx_direct_frame_avail, rx_direct_oe
	);
endinterface : pos_rx_if
`default_nettype wire

// ==== core/pos_rx_fifo.sv ====
// One receive packet FIFO with start, end, pad and error tags per word
`timescale 1ns/1ps
`default_nettype none
module pos_rx_fifo #(
	parameter int DEPTH = pos_rx_pkg::FIFO_DEPTH,
	parameter int PTR_W = pos_rx_pkg::FIFO_PTR_W
) (
	input wire logic mclk,
	input wire logic resetn,
	input wire logic wr_valid,
	input wire logic [69:0] wr_entry,
	output logic wr_ready,
	input wire logic rd_take,
	output logic [69:0] rd_entry,
	output logic rd_nonempty,
	output logic frame_avail
);
	if (DEPTH != (1 << PTR_W)) begin : g_bad_depth
		$error("DEPTH must be 2**PTR_W");
	end
	logic [69:0] mem [DEPTH];
	logic [PTR_W:0] wptr_q;
	logic [PTR_W:0] rptr_q;
	logic [PTR_W:0] eop_cnt_q;
	wire full = (wptr_q - rptr_q) == (PTR_W + 1)'(DEPTH);
	wire do_wr = wr_valid && !full;
	// Reading an empty FIFO never moves a pointer
	wire do_rd = rd_take && rd_nonempty;
	wire wr_eop = wr_entry[68];
	wire rd_eop = rd_entry[68];
	assign wr_ready = !full;
	assign rd_nonempty = wptr_q != rptr_q;
	assign rd_entry = mem[rptr_q[PTR_W-1:0]];
	// A whole packet waiting, or the FIFO at least half full
	assign frame_avail = (eop_cnt_q != '0) || ((wptr_q - rptr_q) >= (PTR_W + 1)'(DEPTH / 2));
	always_ff @(posedge mclk) begin
		if (do_wr) begin
			mem[wptr_q[PTR_W-1:0]] <= wr_entry;
		end
	end
	always_ff @(posedge mclk) begin
		if (!resetn) begin
			wptr_q <= '0;
			rptr_q <= '0;
			eop_cnt_q <= '0;
		end else begin
			wptr_q <= wptr_q + (PTR_W + 1)'(do_wr);
			rptr_q <= rptr_q + (PTR_W + 1)'(do_rd);
			eop_cnt_q <= eop_cnt_q + (PTR_W + 1)'(do_wr && wr_eop) - (PTR_W + 1)'(do_rd && rd_eop);
		end
	end
endmodule : pos_rx_fifo
`default_nettype wire

// ==== core/pos_rx_phy.sv ====
// Receive port end: four packet FIFOs delivered over the shared receive bus
`timescale 1ns/1ps
`default_nettype none
module pos_rx_phy #(
	parameter logic [4:0] DEVICE_ADDR = 5'h00
) (
	input wire logic mclk,
	input wire logic resetn,
	pos_rx_if.phy bus,
	input wire logic rx_select_mode,
	input wire logic rx_valid_boundary_cfg,
	input wire logic rx_decode_delay_cfg,
	input wire logic rx_shared_bus_cfg,
	input wire logic rx_direct_status_cfg,
	input wire logic rx_four_port_cfg,
	input wire logic [1:0] rx_bus_width_cfg,
	input wire logic [4:0] port_base_address,
	input wire logic [3:0] fill_valid,
	input wire logic [63:0] fill_data,
	input wire logic fill_sop,
	input wire logic fill_eop,
	input wire logic [2:0] fill_pad,
	input wire logic fill_err,
	output logic [3:0] fill_ready
);
	localparam int NF = pos_rx_pkg::NUM_FIFOS;
	// Port index is two bits wide, so exactly four FIFOs
	if (NF != 4) begin : g_bad_nf
		$error("NUM_FIFOS must be 4");
	end
	logic [69:0] entry [NF];
	logic [NF-1:0] nonempty;
	logic [NF-1:0] favail;
	logic [NF-1:0] take;
	genvar gi;
	generate
		for (gi = 0; gi < NF; gi++) begin : g_fifo
			pos_rx_fifo u_fifo (
				.mclk(mclk),
				.resetn(resetn),
				.wr_valid(fill_valid[gi]),
				.wr_entry({fill_err, fill_eop, fill_sop, fill_pad, fill_data}),
				.wr_ready(fill_ready[gi]),
				.rd_take(take[gi]),
				.rd_entry(entry[gi]),
				.rd_nonempty(nonempty[gi]),
				.frame_avail(favail[gi])
			);
		end
	endgenerate
	logic enb_prev_q;
	logic [4:0] sel_q;
	logic sel_ok_q;
	logic stopped_q;
	logic stop_req_q;
	wire enb_fall = enb_prev_q && !bus.rx_enable_n;
	// Port taken on the falling enable in polled mode, every cycle in mapped mode
	wire [4:0] cur_port = rx_select_mode ? bus.rx_port_address :
		(enb_fall ? bus.rx_port_address : sel_q);
	wire port_ok = !rx_four_port_cfg ? (cur_port == port_base_address) :
		(cur_port >= port_base_address) && (cur_port < port_base_address + 5'h4);
	wire [1:0] fidx = rx_four_port_cfg ? 2'(cur_port - port_base_address) : 2'h0;
	wire active = !bus.rx_enable_n && (rx_select_mode || enb_fall || sel_ok_q) && port_ok;
	wire [69:0] head = entry[fidx];
	// A boundary stop holds reads too, so the next packet stays queued
	wire boundary_hold = stopped_q;
	// Empty FIFO read is ignored without raising any error flag
	wire rd_go = active && nonempty[fidx] && !boundary_hold;
	wire hit_eop = rd_go && head[68];
	generate
		for (gi = 0; gi < NF; gi++) begin : g_take
			assign take[gi] = rd_go && (fidx == 2'(gi));
		end
	endgenerate
	// Pad field narrowed to the active width; upper bits forced low
	wire [2:0] pad_mask = (rx_bus_width_cfg == pos_rx_pkg::WIDTH_64) ? 3'h7 :
		(rx_bus_width_cfg == pos_rx_pkg::WIDTH_32) ? 3'h3 : 3'h1;
	wire [63:0] data_mask = (rx_bus_width_cfg == pos_rx_pkg::WIDTH_64) ? 64'hffffffffffffffff :
		(rx_bus_width_cfg == pos_rx_pkg::WIDTH_32) ? 64'h00000000ffffffff :
		64'h000000000000ffff;
	// Stage one, used only by the slow decode setting
	logic [69:0] s1_q;
	logic s1_val_q;
	logic s1_drv_q;
	logic s1_eop_q;
	// End flag without a word marks a boundary stop, not an empty FIFO
	wire now_eop = rd_go ? head[68] : (active && stopped_q);
	always_ff @(posedge mclk) begin
		if (!resetn) begin
			enb_prev_q <= 1'b1;
			sel_q <= 5'h00;
			sel_ok_q <= 1'b0;
			stopped_q <= 1'b0;
			stop_req_q <= 1'b0;
			s1_q <= '0;
			s1_val_q <= 1'b0;
			s1_drv_q <= 1'b0;
			s1_eop_q <= 1'b0;
		end else begin
			enb_prev_q <= bus.rx_enable_n;
			if (enb_fall) begin
				sel_q <= bus.rx_port_address;
				sel_ok_q <= port_ok;
				stopped_q <= 1'b0;
			end
			if (bus.rx_enable_n && rx_select_mode) begin
				stopped_q <= 1'b0;
			end
			if (bus.rx_stop_after_packet) begin
				stop_req_q <= 1'b1;
			end
			if (hit_eop && (rx_valid_boundary_cfg || stop_req_q || bus.rx_stop_after_packet)) begin
				stopped_q <= 1'b1;
				stop_req_q <= 1'b0;
			end
			s1_q <= rd_go ? head : s1_q;
			s1_val_q <= rd_go;
			s1_drv_q <= active;
			s1_eop_q <= now_eop;
		end
	end
	// Fast setting answers from the FIFO head, the slow one from stage one
	wire slow = rx_decode_delay_cfg;
	wire [69:0] pick = slow ? s1_q : head;
	wire pick_val = slow ? s1_val_q : rd_go;
	// Shared bus is driven for the whole access, not only for valid words
	wire pick_drv = slow ? s1_drv_q : active;
	wire pick_eop = slow ? s1_eop_q : now_eop;
	wire [63:0] pick_word = pick[63:0] & data_mask;
	// Pad count only means something beside the end flag of a word
	wire [2:0] pick_pad = (pick_val && pick[68]) ? (pick[66:64] & pad_mask) : 3'h0;
	// Polled status path, one or two clocks after the address
	logic p1_q;
	logic p1_oe_q;
	wire [1:0] paddr_idx = 2'(bus.rx_port_address - port_base_address);
	wire paddr_ok = !rx_four_port_cfg ? (bus.rx_port_address == port_base_address) :
		(bus.rx_port_address >= port_base_address) &&
		(bus.rx_port_address < port_base_address + 5'h4);
	wire paddr_me = bus.rx_port_address == DEVICE_ADDR;
	wire base_hit = bus.rx_port_address == port_base_address;
	// Status reports a whole packet or a filling FIFO, not mere emptiness
	wire poll_now = paddr_ok && favail[rx_four_port_cfg ? paddr_idx : 2'h0];
	wire poll_oe_now = !rx_select_mode && (!rx_shared_bus_cfg || paddr_me);
	always_ff @(posedge mclk) begin
		if (!resetn) begin
			p1_q <= 1'b0;
			p1_oe_q <= 1'b0;
		end else begin
			p1_q <= poll_now;
			p1_oe_q <= poll_oe_now;
		end
	end
	// Registered bus outputs; enables high while this end drives the pin
	always_ff @(posedge mclk) begin
		if (!resetn) begin
			bus.rx_word_bus <= 64'h0000000000000000;
			bus.rx_start_of_packet <= 1'b0;
			bus.rx_end_of_packet <= 1'b0;
			bus.rx_pad_count <= 3'h0;
			bus.rx_packet_error <= 1'b0;
			bus.rx_word_valid <= 1'b0;
			bus.rx_bus_parity <= 1'b0;
			bus.rx_word_bus_oe <= 1'b0;
			bus.rx_qual_oe <= 1'b0;
			bus.rx_polled_frame_avail <= 1'b0;
			bus.rx_polled_oe <= 1'b0;
			bus.rx_direct_frame_avail <= 4'h0;
			bus.rx_direct_oe <= 1'b0;
		end else begin
			bus.rx_word_bus <= pick_word;
			bus.rx_start_of_packet <= pick_val && pick[67];
			bus.rx_end_of_packet <= pick_eop;
			bus.rx_pad_count <= pick_pad;
			bus.rx_packet_error <= pick_val && pick[69];
			bus.rx_word_valid <= pick_val;
			bus.rx_bus_parity <= ^pick_word;
			bus.rx_word_bus_oe <= !rx_shared_bus_cfg || pick_drv;
			bus.rx_qual_oe <= !rx_shared_bus_cfg || pick_drv;
			bus.rx_polled_frame_avail <= slow ? p1_q : poll_now;
			bus.rx_polled_oe <= slow ? p1_oe_q : poll_oe_now;
			bus.rx_direct_frame_avail <= favail;
			bus.rx_direct_oe <= rx_direct_status_cfg || base_hit;
		end
	end
endmodule : pos_rx_phy
`default_nettype wire

// ==== core/pos_rx_link.sv ====
// Link-layer end: polls, selects a port and collects received words
`timescale 1ns/1ps
`default_nettype none
module pos_rx_link (
	input wire logic mclk,
	input wire logic resetn,
	pos_rx_if.link bus,
	input wire logic [1:0] cmd,
	input wire logic [4:0] cmd_port,
	input wire logic cmd_stop_after,
	input wire logic cmd_mapped,
	output logic busy,
	output logic [63:0] word_out,
	output logic word_sop,
	output logic word_eop,
	output logic [2:0] word_pad,
	output logic word_err,
	output logic word_strobe,
	output logic poll_status
);
	pos_rx_pkg::link_state_e state_q;
	logic [4:0] port_q;
	logic [3:0] quiet_q;
	always_ff @(posedge mclk) begin
		if (!resetn) begin
			state_q <= pos_rx_pkg::LINK_IDLE;
			port_q <= 5'h00;
			quiet_q <= 4'h0;
			bus.rx_port_address <= 5'h00;
			bus.rx_enable_n <= 1'b1;
			bus.rx_stop_after_packet <= 1'b0;
			busy <= 1'b0;
			word_out <= 64'h0000000000000000;
			word_sop <= 1'b0;
			word_eop <= 1'b0;
			word_pad <= 3'h0;
			word_err <= 1'b0;
			word_strobe <= 1'b0;
			poll_status <= 1'b0;
		end else begin
			// Words without valid are thrown away
			word_strobe <= bus.rx_word_valid;
			word_out <= bus.rx_word_bus;
			word_sop <= bus.rx_start_of_packet;
			word_eop <= bus.rx_end_of_packet;
			word_pad <= bus.rx_pad_count;
			word_err <= bus.rx_packet_error;
			poll_status <= bus.rx_polled_frame_avail;
			case (state_q)
				pos_rx_pkg::LINK_IDLE: begin
					bus.rx_enable_n <= 1'b1;
					bus.rx_stop_after_packet <= 1'b0;
					if (cmd == pos_rx_pkg::CMD_POLL) begin
						bus.rx_port_address <= cmd_port;
					end else if (cmd == pos_rx_pkg::CMD_READ) begin
						bus.rx_port_address <= cmd_port;
						port_q <= cmd_port;
						busy <= 1'b1;
						state_q <= pos_rx_pkg::LINK_SELECT;
					end
				end
				pos_rx_pkg::LINK_SELECT: begin
					bus.rx_enable_n <= 1'b0;
					bus.rx_stop_after_packet <= cmd_stop_after;
					quiet_q <= 4'h0;
					state_q <= pos_rx_pkg::LINK_READ;
				end
				pos_rx_pkg::LINK_READ: begin
					if (cmd == pos_rx_pkg::CMD_POLL && !cmd_mapped) begin
						bus.rx_port_address <= cmd_port;
					end else if (cmd_mapped) begin
						bus.rx_port_address <= port_q;
					end
					quiet_q <= bus.rx_word_valid ? 4'h0 : quiet_q + 4'h1;
					// An empty port never answers, so give up after a silent spell
					if (!bus.rx_word_valid && quiet_q == 4'(pos_rx_pkg::LINK_QUIET_LIMIT)) begin
						bus.rx_enable_n <= 1'b1;
						busy <= 1'b0;
						state_q <= pos_rx_pkg::LINK_IDLE;
					end
					if (bus.rx_word_valid && bus.rx_end_of_packet) begin
						bus.rx_enable_n <= 1'b1;
						busy <= 1'b0;
						state_q <= pos_rx_pkg::LINK_IDLE;
					end
				end
				default: begin
					state_q <= pos_rx_pkg::LINK_IDLE;
				end
			endcase
		end
	end
endmodule : pos_rx_link
`default_nettype wire

// ==== dv/pos_rx_props.sv ====
// Concurrent checks on the receive bus between the port and the link end
`timescale 1ns/1ps
`default_nettype none
module pos_rx_props (
	input wire logic mclk,
	input wire logic resetn,
	input wire logic rx_enable_n,
	input wire logic rx_word_bus_oe,
	input wire logic rx_start_of_packet,
	input wire logic rx_end_of_packet,
	input wire logic [2:0] rx_pad_count,
	input wire logic rx_packet_error,
	input wire logic rx_word_valid,
	input wire logic [63:0] rx_word_bus,
	input wire logic rx_bus_parity,
	input wire logic rx_qual_oe,
	input wire logic rx_polled_oe,
	input wire logic rx_direct_oe
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!resetn);
	reset_quiet_a: assert property (disable iff (1'b0) !resetn |=> rx_enable_n
		&& !rx_word_valid && !rx_qual_oe && !rx_polled_oe && !rx_direct_oe)
		else $error("bus not quiet after reset");
	// One or two edges cover both decode-response settings
	valid_cause_a: assert property (rx_word_valid |->
		!$past(rx_enable_n) || !$past(rx_enable_n, 2)) else $error("valid without enable");
	parity_even_a: assert property (rx_word_valid |-> rx_bus_parity == ^rx_word_bus)
		else $error("parity does not match word");
	idle_enable_a: assert property (rx_enable_n [*3] |=> !rx_word_valid)
		else $error("word delivered while enable high");
	valid_driven_a: assert property (rx_word_valid |-> rx_word_bus_oe && rx_qual_oe)
		else $error("word delivered on released bus");
	start_with_word_a: assert property (rx_start_of_packet |-> rx_word_valid)
		else $error("start flag without word");
	pad_last_a: assert property (rx_word_valid && !rx_end_of_packet |-> rx_pad_count == 3'h0)
		else $error("padding before last word");
	pad_end_a: assert property (rx_pad_count != 3'h0 |-> rx_end_of_packet)
		else $error("pad count without end flag");
	error_word_a: assert property (rx_packet_error |-> rx_word_valid)
		else $error("error flag without word");
	cover property (rx_word_valid && rx_start_of_packet);
	cover property (rx_word_valid && rx_end_of_packet);
	cover property (!rx_word_valid && rx_end_of_packet);
	cover property (rx_polled_oe);
endmodule : pos_rx_props
`default_nettype wire

// ==== dv/pos_utopia_receive_port_tb_top.sv ====
// Bench for the receive port: both ends joined over the receive bus
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin err_count++; \
	$display("unexpected at %0t: got %h want %h", $time, (a), (b)); end end
module pos_utopia_receive_port_tb_top;
	logic mclk = 1'b0;
	logic resetn = 1'b0;
	logic rx_select_mode = 1'b0;
	logic rx_valid_boundary_cfg = 1'b0;
	logic rx_decode_delay_cfg = 1'b0;
	logic rx_shared_bus_cfg = 1'b0;
	logic rx_direct_status_cfg = 1'b1;
	logic [1:0] bus_width = pos_rx_pkg::WIDTH_64;
	logic [3:0] fill_valid = 4'h0;
	logic [63:0] fill_data = 64'h0;
	logic fill_sop = 1'b0;
	logic fill_eop = 1'b0;
	logic [2:0] fill_pad = 3'h0;
	logic fill_err = 1'b0;
	logic [3:0] fill_ready;
	logic [1:0] cmd = 2'h0;
	logic [4:0] cmd_port = 5'h00;
	logic cmd_stop_after = 1'b0;
	logic busy, word_sop, word_eop, word_err, word_strobe, poll_status;
	logic [63:0] word_out;
	logic [2:0] word_pad;
	logic [69:0] exq[4][$];
	logic [69:0] rq[$];
	int err_count = 0;
	int compares = 0;
	int vcnt = 0;
	int bstop = 0;
	pos_rx_if bus ();
	pos_rx_phy u_pos_rx_phy (.mclk(mclk), .resetn(resetn), .bus(bus.phy),
		.rx_select_mode(rx_select_mode), .rx_valid_boundary_cfg(rx_valid_boundary_cfg),
		.rx_decode_delay_cfg(rx_decode_delay_cfg), .rx_shared_bus_cfg(rx_shared_bus_cfg),
		.rx_direct_status_cfg(rx_direct_status_cfg), .rx_four_port_cfg(1'b1),
		.rx_bus_width_cfg(bus_width), .port_base_address(5'h00),
		.fill_valid(fill_valid), .fill_data(fill_data), .fill_sop(fill_sop),
		.fill_eop(fill_eop), .fill_pad(fill_pad), .fill_err(fill_err), .fill_ready(fill_ready));
	pos_rx_link u_pos_rx_link (.mclk(mclk), .resetn(resetn), .bus(bus.link), .cmd(cmd),
		.cmd_port(cmd_port), .cmd_stop_after(cmd_stop_after), .cmd_mapped(rx_select_mode),
		.busy(busy), .word_out(word_out), .word_sop(word_sop), .word_eop(word_eop),
		.word_pad(word_pad), .word_err(word_err), .word_strobe(word_strobe),
		.poll_status(poll_status));
	pos_rx_props u_pos_rx_props (.mclk(mclk), .resetn(resetn), .rx_enable_n(bus.rx_enable_n),
		.rx_word_bus_oe(bus.rx_word_bus_oe), .rx_start_of_packet(bus.rx_start_of_packet),
		.rx_end_of_packet(bus.rx_end_of_packet), .rx_pad_count(bus.rx_pad_count),
		.rx_packet_error(bus.rx_packet_error), .rx_word_valid(bus.rx_word_valid),
		.rx_word_bus(bus.rx_word_bus), .rx_bus_parity(bus.rx_bus_parity),
		.rx_qual_oe(bus.rx_qual_oe), .rx_polled_oe(bus.rx_polled_oe),
		.rx_direct_oe(bus.rx_direct_oe));
	always #4 mclk = ~mclk;
	// Wire-side counts, so word loss is seen even if the link end hides it
	always @(posedge mclk) begin
		if (word_strobe === 1'b1) rq.push_back({word_out, word_sop, word_eop, word_pad, word_err});
		if (bus.rx_word_valid === 1'b1) vcnt++;
		if (bus.rx_word_valid === 1'b0 && bus.rx_end_of_packet === 1'b1) bstop++;
	end
	task automatic complete_run();
		$display("compares %0d, mismatches %0d", compares, err_count);
		if (err_count == 0 && compares > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : complete_run
	// Config is static, so each change goes through a reset, which also empties the FIFOs
	task automatic cfg(input logic [4:0] c);
		resetn <= 1'b0;
		{rx_select_mode, rx_valid_boundary_cfg, rx_decode_delay_cfg, rx_shared_bus_cfg,
			rx_direct_status_cfg} <= c;
		foreach (exq[i]) exq[i].delete();
		repeat (2) @(posedge mclk);
		resetn <= 1'b1;
		repeat (3) @(posedge mclk);
	endtask : cfg
	task automatic put(input int f, input int n, input logic [2:0] pad, input logic err);
		int t;
		for (int k = 0; k < n; k++) begin
			fill_valid <= 4'h1 << f;
			fill_data <= {4'(f), 4'(k), 56'h0123456789abcd};
			fill_sop <= (k == 0);
			fill_eop <= (k == n - 1);
			fill_pad <= (k == n - 1) ? pad : 3'h0;
			fill_err <= (k == n - 1) && err;
			exq[f].push_back({4'(f), 4'(k), 56'h0123456789abcd, k == 0, k == n - 1,
				(k == n - 1) ? pad : 3'h0, (k == n - 1) && err});
			t = 0;
			do begin
				@(posedge mclk);
				t++;
			end while (fill_ready[f] !== 1'b1 && t < 40);
			if (t >= 40) err_count++;
		end
		fill_valid <= 4'h0;
		@(posedge mclk);
	endtask : put
	task automatic issue(input logic [1:0] c, input int p, input logic stop);
		int t;
		cmd <= c;
		cmd_port <= 5'(p);
		cmd_stop_after <= stop;
		vcnt = 0;
		bstop = 0;
		@(posedge mclk);
		cmd <= pos_rx_pkg::CMD_NONE;
		t = 0;
		do begin
			@(posedge mclk);
			t++;
		end while (busy !== 1'b0 && t < 300);
		if (t >= 300) err_count++;
		repeat (4) @(posedge mclk);
	endtask : issue
	task automatic rd(input int p, input logic stop, input int n);
		logic [69:0] w;
		logic [69:0] e;
		issue(pos_rx_pkg::CMD_READ, p, stop);
		`CHK(rq.size(), n)
		`CHK(vcnt, n)
		while (rq.size() > 0 && exq[p].size() > 0) begin
			w = rq.pop_front();
			e = exq[p].pop_front();
			// A 32-bit bus carries the low half of each word and two pad bits
			if (bus_width == pos_rx_pkg::WIDTH_32) e = e & {32'h0, 32'hffffffff, 2'h3, 3'h3, 1'h1};
			`CHK(w, e)
		end
		rq.delete();
	endtask : rd
	task automatic poll(input int p, input logic want);
		issue(pos_rx_pkg::CMD_POLL, p, 1'b0);
		`CHK(poll_status, want)
	endtask : poll
	initial begin
		cfg(5'h01);
		`CHK(bus.rx_qual_oe, 1'b1)
		`CHK(bus.rx_direct_oe, 1'b1)
		put(0, 3, 3'h5, 1'b0);
		poll(0, 1'b1);
		poll(1, 1'b0);
		rd(0, 1'b0, 3);
		rd(2, 1'b0, 0);
		put(2, 2, 3'h0, 1'b1);
		rd(2, 1'b0, 2);
		put(3, 1, 3'h1, 1'b0);
		put(3, 2, 3'h4, 1'b0);
		rd(3, 1'b1, 1);
		rd(3, 1'b0, 2);
		$display("test polled fast done");
		cfg(5'h0e);
		`CHK(bus.rx_qual_oe, 1'b0)
		`CHK(bus.rx_direct_oe, bus.rx_port_address === 5'h00)
		put(1, 2, 3'h2, 1'b0);
		put(1, 3, 3'h7, 1'b0);
		rd(1, 1'b0, 2);
		`CHK(bstop > 0, 1'b1)
		rd(1, 1'b0, 3);
		$display("test boundary slow shared done");
		bus_width <= pos_rx_pkg::WIDTH_32;
		cfg(5'h1d);
		`CHK(bus.rx_polled_oe, 1'b0)
		put(0, 2, 3'h3, 1'b0);
		put(1, 2, 3'h6, 1'b0);
		rd(1, 1'b0, 2);
		`CHK(bus.rx_direct_frame_avail, 4'h1)
		rd(0, 1'b0, 2);
		`CHK(bus.rx_direct_frame_avail, 4'h0)
		$display("test mapped done");
		complete_run();
	end
	initial begin
		repeat (50000) @(posedge mclk);
		err_count++;
		complete_run();
	end
endmodule : pos_utopia_receive_port_tb_top
`default_nettype wire
